// ===== ctrl_model.sv
`timescale 1ns/1ps
// main controller: issues table byte accesses and command ends
module ctrl_model
    import servo_table_pkg::*;
(
    input wire logic clk_in, // system clock
    input wire logic [7:0] rdata_in, // read byte
    output logic wr_out, // write strobe
    output logic rd_out, // read strobe
    output logic [7:0] addr_out, // byte address
    output logic [7:0] wdata_out, // write byte
    output logic done_out, // command end pulse
    output cmd_kind_t kind_out, // command kind
    output logic alln_out, // all-nodes command
    output logic [2:0] err_out // instr, checksum, range events
);
    // idle bus at time zero
    initial begin
        {wr_out, rd_out, done_out, alln_out, err_out, addr_out, wdata_out} = '0;
        kind_out = CMD_PING;
    end
    // byte write, taken at the next rising edge; address scrambled after
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        {wr_out, addr_out, wdata_out} = {1'b1, a, d};
        @(negedge clk_in);
        wr_out = 1'b0;
        addr_out = ~a;
    endtask
    // both bytes of a wide value go in one command, low byte first
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    // byte read, data taken one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        {rd_out, addr_out} = {1'b1, a};
        @(negedge clk_in);
        rd_out = 1'b0;
        d = rdata_in;
    endtask
    // error events pulse during the command, the end pulse follows;
    // returns in the reply cycle
    task automatic cmd(input cmd_kind_t k, input logic n, input logic [2:0] e);
        @(negedge clk_in);
        {alln_out, err_out} = {n, e};
        kind_out = k;
        @(negedge clk_in);
        {done_out, err_out} = {1'b1, 3'b000};
        @(negedge clk_in);
        done_out = 1'b0;
    endtask
endmodule

// ===== servo_control_table.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] angle bounds accept 0..1023 codes
// [R2] temperature above ceiling sets error bit 2
// [R3] ceiling in Celsius, initial value 80
// [R4] voltage outside floor/ceiling sets error bit 0
// [R5] stored max torque copied to live cap
// [R6] torque values are linear output fractions
// [R7] policy 0 none, 1 reads, 2 all
// [R8] never reply all-nodes, always reply ping
// [R9] flash lamp on any indicator-masked error
// [R10] flashing stops two seconds after clearing
// [R11] fixed error bit layout, bit 7 zero
// [R12] goal outside bounds raises angle error
// [R13] shutdown-masked error switches torque off
// [R14] shutdown held until torque cap written
// [R15] no torque until drive enable written 1
// [R16] lamp follows lamp register
// [R17] margin 0..254, slope 1..254 accepted
// [R18] slope quantized to seven effective levels
// [R19] goal and present position 0..1023
// [R20] speed 0..1023, zero means unregulated
// [R21] live torque cap limits output torque
// [R22] load: ratio 9..0, direction bit 10
// [R23] controller writes both bytes in one command
// [R24] volatile entries reload at every reset
// [R25] error bits persist and go in replies
module servo_control_table
    import servo_table_pkg::*;
#(
    parameter longint HOLD_CYC = FLASH_HOLD_CYC,
    parameter longint BLINK_CYC = BLINK_HALF_CYC
) (
    input wire logic clk_sys_in, // system clock
    input wire logic arst_n_in, // async reset, active low
    input wire logic tbl_wr_in, // table byte write strobe
    input wire logic tbl_rd_in, // table byte read strobe
    input wire logic [7:0] tbl_addr_in, // table byte address
    input wire logic [7:0] tbl_wdata_in, // write byte
    output logic [7:0] tbl_rdata_out, // read byte, one cycle after strobe
    input wire logic cmd_done_in, // command finished pulse
    input wire cmd_kind_t cmd_kind_in, // kind of finished command
    input wire logic cmd_all_nodes_in, // command used all_nodes_identifier
    input wire logic instr_err_in, // undefined command or empty trigger
    input wire logic checksum_err_in, // bad checksum seen
    input wire logic range_err_in, // out-of-range command seen
    output logic reply_send_out, // send a reply, pulse
    output logic [7:0] reply_err_out, // error byte of the reply
    input wire logic overload_pin_in, // load beyond torque, async
    input wire logic [7:0] temp_pin_in, // temperature in Celsius, async
    input wire logic [7:0] volt_pin_in, // supply in tenths of volt, async
    input wire logic [9:0] pos_pin_in, // present position, async
    input wire logic [9:0] rate_pin_in, // present speed, async
    input wire logic [10:0] load_pin_in, // present load, async
    output logic [9:0] goal_out, // goal position
    output logic [9:0] speed_out, // moving speed, 0 unregulated
    output logic [9:0] torque_cap_out, // effective torque fraction
    output logic [7:0] cw_margin_out, // cw zero-torque band
    output logic [7:0] ccw_margin_out, // ccw zero-torque band
    output logic [7:0] cw_slope_out, // cw effective slope
    output logic [7:0] ccw_slope_out, // ccw effective slope
    output logic lamp_out // indicator lamp drive
);
    // reset release through two flops
    logic rst_q1_r;
    logic rst_n;
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_q1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_n <= rst_q1_r;
        end
    end

    // sensor pins: three stages, a bit changes when stages two and three agree
    localparam int SW = 48;
    logic [SW-1:0] sens_s1_r, sens_s2_r, sens_s3_r, sens_r;
    wire [SW-1:0] sens_pins = {overload_pin_in, temp_pin_in, volt_pin_in,
                               pos_pin_in, rate_pin_in, load_pin_in};
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            sens_s1_r <= '0;
            sens_s2_r <= '0;
            sens_s3_r <= '0;
            sens_r <= '0;
        end else begin
            sens_s1_r <= sens_pins;
            sens_s2_r <= sens_s1_r;
            sens_s3_r <= sens_s2_r;
            sens_r <= (sens_s2_r & sens_s3_r) | (sens_r & (sens_s2_r | sens_s3_r));
        end
    end
    wire overload_q = sens_r[47];
    wire [7:0] temp_q = sens_r[46:39];
    wire [7:0] volt_q = sens_r[38:31];
    wire [9:0] pos_q = sens_r[30:21];
    wire [9:0] rate_q = sens_r[20:11];
    wire [10:0] load_q = sens_r[10:0];

    // slope quantizer
    function automatic logic [7:0] slope_level(input logic [7:0] s);
        if (s >= 8'hc0) slope_level = 8'hfe;
        else if (s >= 8'h60) slope_level = 8'h80;
        else if (s >= 8'h30) slope_level = 8'h40;
        else if (s >= 8'h18) slope_level = 8'h20;
        else if (s >= 8'h0c) slope_level = 8'h10;
        else if (s >= 8'h06) slope_level = 8'h08;
        else slope_level = 8'h04;
    endfunction

    // table storage
    logic [9:0] cw_bound_r, ccw_bound_r, torque_stored_r, goal_r, speed_r, cap_live_r;
    logic [7:0] temp_ceil_r, volt_floor_r, volt_ceil_r, policy_r, ind_mask_r, shut_mask_r;
    logic [7:0] cw_margin_r, ccw_margin_r, cw_slope_r, ccw_slope_r;
    logic drive_on_r, lamp_r;

    // write acceptance per address and value
    wire [7:0] wd = tbl_wdata_in;
    wire hi10_ok = (wd <= 8'h03);
    logic wr_valid;
    always_comb begin
        case (tbl_addr_in)
            ADDR_CW_BOUND_LO, ADDR_CCW_BOUND_LO, ADDR_TORQUE_STORED_LO, ADDR_IND_MASK,
            ADDR_SHUT_MASK, ADDR_GOAL_LO, ADDR_SPEED_LO, ADDR_CAP_LO: wr_valid = 1'b1;
            ADDR_CW_BOUND_HI, ADDR_CCW_BOUND_HI, ADDR_TORQUE_STORED_HI,
            ADDR_GOAL_HI, ADDR_SPEED_HI, ADDR_CAP_HI: wr_valid = hi10_ok; // R1 R5 R19 R20 R21
            ADDR_TEMP_CEIL: wr_valid = (wd >= TEMP_MIN) && (wd <= TEMP_MAX); // R2
            ADDR_VOLT_FLOOR, ADDR_VOLT_CEIL: wr_valid = (wd >= VOLT_MIN) && (wd <= VOLT_MAX); // R4
            ADDR_REPLY_POLICY: wr_valid = (wd <= POLICY_MAX); // R7
            ADDR_DRIVE_ON, ADDR_LAMP: wr_valid = (wd <= 8'h01);
            ADDR_CW_MARGIN, ADDR_CCW_MARGIN: wr_valid = (wd <= SOFT_MAX); // R17
            ADDR_CW_SLOPE, ADDR_CCW_SLOPE: wr_valid = (wd != 8'h00) && (wd <= SOFT_MAX); // R17
            default: wr_valid = 1'b0;
        endcase
    end
    wire wr_ok = tbl_wr_in && wr_valid;
    wire wr_bad = tbl_wr_in && !wr_valid;
    wire cap_wr = wr_ok && ((tbl_addr_in == ADDR_CAP_LO) || (tbl_addr_in == ADDR_CAP_HI));
    wire goal_hi_wr = wr_ok && (tbl_addr_in == ADDR_GOAL_HI);
    wire [9:0] goal_new = {wd[1:0], goal_r[7:0]};
    // both bounds zero is the endless-turn setting, which has no span
    wire endless = (cw_bound_r == 10'h000) && (ccw_bound_r == 10'h000);
    wire goal_outside = !endless && ((goal_new < cw_bound_r) || (goal_new > ccw_bound_r));

    // byte writes into the table; all entries reload at reset
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin // R24
            cw_bound_r <= RST_CW_BOUND;
            ccw_bound_r <= RST_CCW_BOUND;
            temp_ceil_r <= RST_TEMP_CEIL; // R3
            volt_floor_r <= RST_VOLT_FLOOR;
            volt_ceil_r <= RST_VOLT_CEIL;
            torque_stored_r <= RST_TORQUE_STORED;
            policy_r <= RST_REPLY_POLICY;
            ind_mask_r <= RST_ERR_MASK;
            shut_mask_r <= RST_ERR_MASK;
            drive_on_r <= 1'b0; // R15
            lamp_r <= 1'b0;
            cw_margin_r <= 8'h00;
            ccw_margin_r <= 8'h00;
            cw_slope_r <= RST_SLOPE;
            ccw_slope_r <= RST_SLOPE;
            goal_r <= 10'h000;
            speed_r <= 10'h000;
            cap_live_r <= RST_TORQUE_STORED; // R5
        end else if (wr_ok) begin
            case (tbl_addr_in)
                ADDR_CW_BOUND_LO: cw_bound_r[7:0] <= wd;
                ADDR_CW_BOUND_HI: cw_bound_r[9:8] <= wd[1:0];
                ADDR_CCW_BOUND_LO: ccw_bound_r[7:0] <= wd;
                ADDR_CCW_BOUND_HI: ccw_bound_r[9:8] <= wd[1:0];
                ADDR_TEMP_CEIL: temp_ceil_r <= wd;
                ADDR_VOLT_FLOOR: volt_floor_r <= wd;
                ADDR_VOLT_CEIL: volt_ceil_r <= wd;
                ADDR_TORQUE_STORED_LO: torque_stored_r[7:0] <= wd;
                ADDR_TORQUE_STORED_HI: torque_stored_r[9:8] <= wd[1:0];
                ADDR_REPLY_POLICY: policy_r <= wd;
                ADDR_IND_MASK: ind_mask_r <= {1'b0, wd[6:0]};
                ADDR_SHUT_MASK: shut_mask_r <= {1'b0, wd[6:0]};
                ADDR_DRIVE_ON: drive_on_r <= wd[0];
                ADDR_LAMP: lamp_r <= wd[0];
                ADDR_CW_MARGIN: cw_margin_r <= wd;
                ADDR_CCW_MARGIN: ccw_margin_r <= wd;
                ADDR_CW_SLOPE: cw_slope_r <= wd;
                ADDR_CCW_SLOPE: ccw_slope_r <= wd;
                ADDR_GOAL_LO: goal_r[7:0] <= wd;
                ADDR_GOAL_HI: goal_r[9:8] <= wd[1:0];
                ADDR_SPEED_LO: speed_r[7:0] <= wd;
                ADDR_SPEED_HI: speed_r[9:8] <= wd[1:0];
                ADDR_CAP_LO: cap_live_r[7:0] <= wd;
                ADDR_CAP_HI: cap_live_r[9:8] <= wd[1:0];
                default: cap_live_r <= cap_live_r;
            endcase
        end
    end

    // read multiplexer
    logic [7:0] rd_byte;
    always_comb begin
        case (tbl_addr_in)
            ADDR_CW_BOUND_LO: rd_byte = cw_bound_r[7:0];
            ADDR_CW_BOUND_HI: rd_byte = {6'h00, cw_bound_r[9:8]};
            ADDR_CCW_BOUND_LO: rd_byte = ccw_bound_r[7:0];
            ADDR_CCW_BOUND_HI: rd_byte = {6'h00, ccw_bound_r[9:8]};
            ADDR_TEMP_CEIL: rd_byte = temp_ceil_r;
            ADDR_VOLT_FLOOR: rd_byte = volt_floor_r;
            ADDR_VOLT_CEIL: rd_byte = volt_ceil_r;
            ADDR_TORQUE_STORED_LO: rd_byte = torque_stored_r[7:0];
            ADDR_TORQUE_STORED_HI: rd_byte = {6'h00, torque_stored_r[9:8]};
            ADDR_REPLY_POLICY: rd_byte = policy_r;
            ADDR_IND_MASK: rd_byte = ind_mask_r;
            ADDR_SHUT_MASK: rd_byte = shut_mask_r;
            ADDR_DRIVE_ON: rd_byte = {7'h00, drive_on_r};
            ADDR_LAMP: rd_byte = {7'h00, lamp_r};
            ADDR_CW_MARGIN: rd_byte = cw_margin_r;
            ADDR_CCW_MARGIN: rd_byte = ccw_margin_r;
            ADDR_CW_SLOPE: rd_byte = cw_slope_r;
            ADDR_CCW_SLOPE: rd_byte = ccw_slope_r;
            ADDR_GOAL_LO: rd_byte = goal_r[7:0];
            ADDR_GOAL_HI: rd_byte = {6'h00, goal_r[9:8]};
            ADDR_SPEED_LO: rd_byte = speed_r[7:0];
            ADDR_SPEED_HI: rd_byte = {6'h00, speed_r[9:8]};
            ADDR_CAP_LO: rd_byte = cap_live_r[7:0];
            ADDR_CAP_HI: rd_byte = {6'h00, cap_live_r[9:8]};
            ADDR_POS_LO: rd_byte = pos_q[7:0]; // R19
            ADDR_POS_HI: rd_byte = {6'h00, pos_q[9:8]};
            ADDR_RATE_LO: rd_byte = rate_q[7:0];
            ADDR_RATE_HI: rd_byte = {6'h00, rate_q[9:8]};
            ADDR_LOAD_LO: rd_byte = load_q[7:0];
            ADDR_LOAD_HI: rd_byte = {5'h00, load_q[10:8]}; // R22
            default: rd_byte = 8'h00;
        endcase
    end

    // error conditions
    wire heat_err = (temp_q > temp_ceil_r); // R2
    wire volt_err = (volt_q < volt_floor_r) || (volt_q > volt_ceil_r); // R4
    logic angle_err_r;
    logic [2:0] cmd_err_r; // instruction, checksum, range
    wire [2:0] cmd_err_set = {instr_err_in, checksum_err_in, range_err_in | wr_bad};
    // angle flag follows the last goal written; command flags last until the
    // command that raised them ends, replied or not, a new event in that cycle wins
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            angle_err_r <= 1'b0;
            cmd_err_r <= 3'h0;
        end else begin
            if (goal_hi_wr) angle_err_r <= goal_outside; // R12
            cmd_err_r <= cmd_err_set | (cmd_done_in ? 3'h0 : cmd_err_r); // R25
        end
    end
    wire [2:0] cmd_err_now = cmd_err_r | cmd_err_set;
    // R11
    wire [7:0] err_bits = {1'b0, cmd_err_now[2], overload_q, cmd_err_now[1], cmd_err_now[0],
                           heat_err, angle_err_r, volt_err};

    // reply decision
    wire reply_want = !cmd_all_nodes_in && ((cmd_kind_in == CMD_PING) // R8
                      || (policy_r == 8'h02)
                      || ((policy_r == 8'h01) && (cmd_kind_in == CMD_READ))); // R7

    // shutdown latch: set wins over the clearing cap write
    logic shutdown_r;
    wire shut_hit = |(err_bits & shut_mask_r); // R13
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) shutdown_r <= 1'b0;
        else shutdown_r <= shut_hit | (shutdown_r & !cap_wr); // R14
    end

    // indicator flashing with hold after the error clears
    wire ind_hit = |(err_bits & ind_mask_r); // R9
    logic [31:0] hold_cnt_r, blink_cnt_r;
    logic blink_r;
    wire flashing = ind_hit || (hold_cnt_r != 32'h0);
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_r <= 32'h0;
            blink_cnt_r <= 32'h0;
            blink_r <= 1'b0;
        end else begin
            if (ind_hit) hold_cnt_r <= 32'(HOLD_CYC); // R10
            else if (hold_cnt_r != 32'h0) hold_cnt_r <= hold_cnt_r - 32'h1;
            if (!flashing || blink_cnt_r >= 32'(BLINK_CYC - 1)) blink_cnt_r <= 32'h0;
            else blink_cnt_r <= blink_cnt_r + 32'h1;
            if (!flashing) blink_r <= 1'b0;
            else if (blink_cnt_r >= 32'(BLINK_CYC - 1)) blink_r <= !blink_r;
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tbl_rdata_out <= 8'h00;
            reply_send_out <= 1'b0;
            reply_err_out <= 8'h00;
            goal_out <= 10'h000;
            speed_out <= 10'h000;
            torque_cap_out <= 10'h000;
            cw_margin_out <= 8'h00;
            ccw_margin_out <= 8'h00;
            cw_slope_out <= RST_SLOPE;
            ccw_slope_out <= RST_SLOPE;
            lamp_out <= 1'b0;
        end else begin
            if (tbl_rd_in) tbl_rdata_out <= rd_byte;
            reply_send_out <= cmd_done_in && reply_want;
            if (cmd_done_in) reply_err_out <= err_bits; // R25
            goal_out <= goal_r;
            speed_out <= speed_r; // R20
            // fraction of available torque, zero off or shut down
            torque_cap_out <= (shutdown_r || !drive_on_r) ? 10'h000 : cap_live_r; // R6 R15 R21
            cw_margin_out <= cw_margin_r; // R17
            ccw_margin_out <= ccw_margin_r;
            cw_slope_out <= slope_level(cw_slope_r); // R18
            ccw_slope_out <= slope_level(ccw_slope_r);
            lamp_out <= lamp_r || blink_r; // R16
        end
    end

    // checks
    property p_no_all_nodes_reply; // R8
        @(posedge clk_sys_in) disable iff (!rst_n)
        cmd_done_in && cmd_all_nodes_in |=> !reply_send_out;
    endproperty
    a_no_all_nodes_reply: assert property (p_no_all_nodes_reply) // R8
        else $error("reply to all nodes");
    property p_ping_reply; // R8
        @(posedge clk_sys_in) disable iff (!rst_n)
        cmd_done_in && !cmd_all_nodes_in && cmd_kind_in == CMD_PING |=> reply_send_out;
    endproperty
    a_ping_reply: assert property (p_ping_reply) else $error("ping not answered"); // R8
    property p_policy_silent; // R7
        @(posedge clk_sys_in) disable iff (!rst_n)
        cmd_done_in && policy_r == 8'h00 && cmd_kind_in != CMD_PING |=> !reply_send_out;
    endproperty
    a_policy_silent: assert property (p_policy_silent) else $error("reply under policy 0"); // R7
    property p_shutdown_hold; // R14
        @(posedge clk_sys_in) disable iff (!rst_n)
        shutdown_r && !cap_wr |=> shutdown_r && torque_cap_out == 10'h000;
    endproperty
    a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown left early"); // R14
    property p_shutdown_torque; // R13
        @(posedge clk_sys_in) disable iff (!rst_n)
        shut_hit |=> shutdown_r ##1 torque_cap_out == 10'h000;
    endproperty
    a_shutdown_torque: assert property (p_shutdown_torque) else $error("torque not cut"); // R13
    property p_heat_bit; // R2
        @(posedge clk_sys_in) disable iff (!rst_n)
        cmd_done_in && temp_q > temp_ceil_r |=> reply_err_out[ERR_HEAT];
    endproperty
    a_heat_bit: assert property (p_heat_bit) else $error("heat bit missing"); // R2
    property p_volt_bit; // R4
        @(posedge clk_sys_in) disable iff (!rst_n)
        cmd_done_in && volt_q < volt_floor_r |=> reply_err_out[ERR_VOLT];
    endproperty
    a_volt_bit: assert property (p_volt_bit) else $error("voltage bit missing"); // R4
    property p_angle_bit; // R12
        @(posedge clk_sys_in) disable iff (!rst_n)
        goal_hi_wr && goal_outside |=> angle_err_r;
    endproperty
    a_angle_bit: assert property (p_angle_bit) else $error("angle error missing"); // R12
    property p_slope_level; // R18
        @(posedge clk_sys_in) disable iff (!rst_n)
        cw_slope_r >= 8'h18 && cw_slope_r <= 8'h2f |=> cw_slope_out == 8'h20;
    endproperty
    a_slope_level: assert property (p_slope_level) else $error("slope level wrong"); // R18
    property p_hold_load; // R10
        @(posedge clk_sys_in) disable iff (!rst_n)
        $fell(ind_hit) |-> hold_cnt_r == 32'(HOLD_CYC);
    endproperty
    a_hold_load: assert property (p_hold_load) else $error("flash hold not loaded"); // R10
    property p_drive_off; // R15
        @(posedge clk_sys_in) disable iff (!rst_n)
        !drive_on_r |=> torque_cap_out == 10'h000;
    endproperty
    a_drive_off: assert property (p_drive_off) else $error("torque while drive off"); // R15
    property p_lamp_on; // R16
        @(posedge clk_sys_in) disable iff (!rst_n)
        lamp_r |=> lamp_out;
    endproperty
    a_lamp_on: assert property (p_lamp_on) else $error("lamp register ignored"); // R16
endmodule

// ===== servo_table_pkg.sv
package servo_table_pkg;
    // table byte addresses
    localparam logic [7:0] ADDR_CW_BOUND_LO = 8'h06;
    localparam logic [7:0] ADDR_CW_BOUND_HI = 8'h07;
    localparam logic [7:0] ADDR_CCW_BOUND_LO = 8'h08;
    localparam logic [7:0] ADDR_CCW_BOUND_HI = 8'h09;
    localparam logic [7:0] ADDR_TEMP_CEIL = 8'h0b;
    localparam logic [7:0] ADDR_VOLT_FLOOR = 8'h0c;
    localparam logic [7:0] ADDR_VOLT_CEIL = 8'h0d;
    localparam logic [7:0] ADDR_TORQUE_STORED_LO = 8'h0e;
    localparam logic [7:0] ADDR_TORQUE_STORED_HI = 8'h0f;
    localparam logic [7:0] ADDR_REPLY_POLICY = 8'h10;
    localparam logic [7:0] ADDR_IND_MASK = 8'h11;
    localparam logic [7:0] ADDR_SHUT_MASK = 8'h12;
    localparam logic [7:0] ADDR_DRIVE_ON = 8'h18;
    localparam logic [7:0] ADDR_LAMP = 8'h19;
    localparam logic [7:0] ADDR_CW_MARGIN = 8'h1a;
    localparam logic [7:0] ADDR_CCW_MARGIN = 8'h1b;
    localparam logic [7:0] ADDR_CW_SLOPE = 8'h1c;
    localparam logic [7:0] ADDR_CCW_SLOPE = 8'h1d;
    localparam logic [7:0] ADDR_GOAL_LO = 8'h1e;
    localparam logic [7:0] ADDR_GOAL_HI = 8'h1f;
    localparam logic [7:0] ADDR_SPEED_LO = 8'h20;
    localparam logic [7:0] ADDR_SPEED_HI = 8'h21;
    localparam logic [7:0] ADDR_CAP_LO = 8'h22;
    localparam logic [7:0] ADDR_CAP_HI = 8'h23;
    localparam logic [7:0] ADDR_POS_LO = 8'h24;
    localparam logic [7:0] ADDR_POS_HI = 8'h25;
    localparam logic [7:0] ADDR_RATE_LO = 8'h26;
    localparam logic [7:0] ADDR_RATE_HI = 8'h27;
    localparam logic [7:0] ADDR_LOAD_LO = 8'h28;
    localparam logic [7:0] ADDR_LOAD_HI = 8'h29;
    // reset values
    localparam logic [9:0] RST_CW_BOUND = 10'h000;
    localparam logic [9:0] RST_CCW_BOUND = 10'h3ff;
    localparam logic [7:0] RST_TEMP_CEIL = 8'h50;
    localparam logic [7:0] RST_VOLT_FLOOR = 8'h3c;
    localparam logic [7:0] RST_VOLT_CEIL = 8'hf0;
    localparam logic [9:0] RST_TORQUE_STORED = 10'h3ff;
    localparam logic [7:0] RST_REPLY_POLICY = 8'h02;
    localparam logic [7:0] RST_ERR_MASK = 8'h24;
    localparam logic [7:0] RST_SLOPE = 8'h20;
    // value ranges
    localparam logic [7:0] TEMP_MIN = 8'h0a;
    localparam logic [7:0] TEMP_MAX = 8'h63;
    localparam logic [7:0] VOLT_MIN = 8'h32;
    localparam logic [7:0] VOLT_MAX = 8'hfa;
    localparam logic [7:0] SOFT_MAX = 8'hfe;
    localparam logic [7:0] POLICY_MAX = 8'h02;
    // error bit positions
    localparam int ERR_VOLT = 0;
    localparam int ERR_ANGLE = 1;
    localparam int ERR_HEAT = 2;
    localparam int ERR_RANGE = 3;
    localparam int ERR_CHECKSUM = 4;
    localparam int ERR_OVERLOAD = 5;
    localparam int ERR_INSTR = 6;
    // timing
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint FLASH_HOLD_MS = 2000;
    localparam longint FLASH_HOLD_CYC = FLASH_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    localparam longint BLINK_HALF_MS = 250;
    localparam longint BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
    // kind of command that has just finished
    typedef enum logic [1:0] {
        CMD_PING = 2'b00,
        CMD_READ = 2'b01,
        CMD_WRITE = 2'b10,
        CMD_OTHER = 2'b11
    } cmd_kind_t;
endpackage

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top
    import servo_table_pkg::*;
;
    localparam longint HOLD = 20;
    logic clk = 1'b0, arst_n = 1'b0, ovl = 1'b0, wr, rd, done, alln, lamp, rsend;
    logic [7:0] addr, wd, rdat, rerr, d, cwm, ccwm, cws, ccws;
    logic [7:0] temp = 8'h19, volt = 8'h64;
    logic [9:0] pos = '0, rate = '0, goal, spd, cap;
    logic [10:0] load = '0;
    logic [2:0] cerr;
    cmd_kind_t kind;
    int fails = 0, compares = 0, cyc = 0, ones;
    // reset rows: address, expected byte
    logic [15:0] rst_rows [16] = '{16'h0600, 16'h08ff, 16'h0903, 16'h0b50, 16'h0c3c,
        16'h0df0, 16'h0eff, 16'h0f03, 16'h1002, 16'h1124, 16'h1224, 16'h1800,
        16'h1c20, 16'h22ff, 16'h2303, 16'h0500};
    // slope rows: written value, effective value
    logic [15:0] sl_rows [7] = '{16'h0504, 16'h0608, 16'h1710, 16'h1820, 16'h5f40,
        16'h6080, 16'hc0fe};
    always #5 clk = ~clk;
    servo_control_table #(.HOLD_CYC(HOLD), .BLINK_CYC(4)) dut (.clk_sys_in(clk),
        .arst_n_in(arst_n), .tbl_wr_in(wr), .tbl_rd_in(rd), .tbl_addr_in(addr),
        .tbl_wdata_in(wd), .tbl_rdata_out(rdat), .cmd_done_in(done), .cmd_kind_in(kind),
        .cmd_all_nodes_in(alln), .instr_err_in(cerr[2]), .checksum_err_in(cerr[1]),
        .range_err_in(cerr[0]), .reply_send_out(rsend), .reply_err_out(rerr),
        .overload_pin_in(ovl), .temp_pin_in(temp), .volt_pin_in(volt), .pos_pin_in(pos),
        .rate_pin_in(rate), .load_pin_in(load), .goal_out(goal), .speed_out(spd),
        .torque_cap_out(cap), .cw_margin_out(cwm), .ccw_margin_out(ccwm),
        .cw_slope_out(cws), .ccw_slope_out(ccws), .lamp_out(lamp));
    ctrl_model m (.clk_in(clk), .rdata_in(rdat), .wr_out(wr), .rd_out(rd), .addr_out(addr),
        .wdata_out(wd), .done_out(done), .kind_out(kind), .alln_out(alln), .err_out(cerr));
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // verdict and end of run
    task automatic close_out;
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    // main sequence
    initial begin
        w(4);
        arst_n = 1'b1;
        w(3);
        foreach (rst_rows[i]) begin
            m.rd(rst_rows[i][15:8], d);
            `CHK(d, rst_rows[i][7:0])
        end
        `CHK(cap, 10'h000)
        for (int p = 0; p < 3; p++) begin
            m.wr(ADDR_REPLY_POLICY, 8'(p));
            for (int k = 0; k < 4; k++) begin
                m.cmd(cmd_kind_t'(k), 1'b0, 3'b000);
                `CHK(rsend, 1'(k == 0 || p == 2 || (p == 1 && k == 1)))
            end
            m.cmd(CMD_PING, 1'b1, 3'b000);
            `CHK(rsend, 1'b0)
        end
        m.cmd(CMD_OTHER, 1'b0, 3'b111);
        `CHK(rerr, 8'h58)
        m.wr(ADDR_TEMP_CEIL, 8'h64);
        m.wr(ADDR_POS_LO, 8'h00);
        m.rd(ADDR_TEMP_CEIL, d);
        `CHK(d, 8'h50)
        m.cmd(CMD_READ, 1'b0, 3'b000);
        `CHK(rerr, 8'h08)
        foreach (sl_rows[i]) begin
            m.wr(ADDR_CW_SLOPE, sl_rows[i][15:8]);
            m.wr(ADDR_CCW_SLOPE, sl_rows[i][15:8]);
            w(2);
            `CHK(cws, sl_rows[i][7:0])
            `CHK(ccws, sl_rows[i][7:0])
        end
        m.wr(ADDR_CW_MARGIN, 8'hfe);
        m.wr(ADDR_CCW_MARGIN, 8'h7f);
        w(2);
        `CHK(cwm, 8'hfe)
        `CHK(ccwm, 8'h7f)
        pos = 10'h155;
        load = 11'h5aa;
        w(8);
        m.rd(ADDR_POS_HI, d);
        `CHK(d, 8'h01)
        m.rd(ADDR_LOAD_HI, d);
        `CHK(d, 8'h05)
        m.wr(ADDR_DRIVE_ON, 8'h01);
        w(2);
        `CHK(cap, 10'h3ff)
        m.wr16(ADDR_CAP_LO, 16'h0200);
        w(2);
        `CHK(cap, 10'h200)
        m.wr(ADDR_LAMP, 8'h01);
        w(2);
        `CHK(lamp, 1'b1)
        m.wr(ADDR_LAMP, 8'h00);
        w(2);
        `CHK(lamp, 1'b0)
        temp = 8'h51;
        w(10);
        m.cmd(CMD_READ, 1'b0, 3'b000);
        `CHK(rerr, 8'h04)
        `CHK(cap, 10'h000)
        ones = 0;
        repeat (12) begin
            w(1);
            ones += int'(lamp);
        end
        `CHK(1'(ones > 0), 1'b1)
        temp = 8'h19;
        w(10);
        `CHK(cap, 10'h000)
        w(HOLD + 10);
        `CHK(lamp, 1'b0)
        m.wr16(ADDR_CAP_LO, 16'h03ff);
        w(2);
        `CHK(cap, 10'h3ff)
        volt = 8'h28;
        w(10);
        m.cmd(CMD_READ, 1'b0, 3'b000);
        `CHK(rerr, 8'h01)
        volt = 8'h64;
        ovl = 1'b1;
        rate = 10'h2c3;
        w(10);
        m.cmd(CMD_READ, 1'b0, 3'b000);
        `CHK(rerr, 8'h20)
        `CHK(cap, 10'h000)
        m.rd(ADDR_RATE_LO, d);
        `CHK(d, 8'hc3)
        ovl = 1'b0;
        w(10);
        m.wr16(ADDR_CCW_BOUND_LO, 16'h0200);
        m.wr16(ADDR_GOAL_LO, 16'h0300);
        w(2);
        `CHK(goal, 10'h300)
        m.cmd(CMD_READ, 1'b0, 3'b000);
        `CHK(rerr, 8'h02)
        m.wr16(ADDR_GOAL_LO, 16'h0100);
        m.cmd(CMD_READ, 1'b0, 3'b000);
        `CHK(rerr, 8'h00)
        m.wr16(ADDR_SPEED_LO, 16'h0001);
        w(2);
        `CHK(spd, 10'h001)
        arst_n = 1'b0;
        w(2);
        arst_n = 1'b1;
        w(3);
        m.rd(ADDR_SPEED_LO, d);
        `CHK(d, 8'h00)
        close_out();
    end
endmodule
